// File: core/smd_pkg.sv
// Constants, register map and operation codes of the signed multiply unit.
// Assumes a 32-bit Avalon-MM slave port with byte addresses and one word per register.
package smd_pkg;

    // Datapath widths
    localparam int DATA_W   = 32;
    localparam int HALF_W   = 16;
    localparam int WIDE_W   = 64;
    localparam int WH_W     = 48;
    localparam int ADDR_W   = 5;
    localparam int BE_W     = 4;
    localparam int BYTE_W   = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] REG_FIRST  = 5'h00;
    localparam logic [ADDR_W-1:0] REG_SECOND = 5'h04;
    localparam logic [ADDR_W-1:0] REG_ACCUM  = 5'h08;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 5'h0c;
    localparam logic [ADDR_W-1:0] REG_RESULT = 5'h10;
    localparam logic [ADDR_W-1:0] REG_COND   = 5'h14;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h18;
    localparam logic [ADDR_W-1:0] REG_MASK   = 5'h1c;

    // Control register layout
    localparam int CTRL_W         = 8;
    localparam int CTRL_OP_LSB    = 0;
    localparam int CTRL_OP_W      = 4;
    localparam int CTRL_ROUND_BIT = 4;
    localparam int CTRL_EXCH_BIT  = 5;
    localparam int CTRL_SELA_BIT  = 6;
    localparam int CTRL_SELB_BIT  = 7;
    localparam int CTRL_START_BIT = 31;

    // Condition flags held in the top nibble
    localparam int COND_LSB = 28;
    localparam int COND_W   = 4;

    // Status and mask layout
    localparam int STAT_W        = 2;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_SAT_BIT  = 1;

    // Reset values
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [CTRL_W-1:0] RST_CTRL = 8'h00;
    localparam logic [COND_W-1:0] RST_COND = 4'h0;
    localparam logic [STAT_W-1:0] RST_STAT = 2'h0;

    // Rounding constant added to the full product
    localparam logic [WIDE_W-1:0] ROUND_CONST = 64'h0000_0000_8000_0000;
    localparam logic [WIDE_W-1:0] ZERO_WIDE   = 64'h0000_0000_0000_0000;

    // Operation codes in the control register
    typedef enum logic [CTRL_OP_W-1:0] {
        OP_MSW_MULTIPLY,
        OP_MSW_MULTIPLY_ACCUMULATE,
        OP_MSW_MULTIPLY_SUBTRACT,
        OP_DUAL_PRODUCT_SUM,
        OP_DUAL_PRODUCT_DIFFERENCE,
        OP_HALFWORD_BY_HALFWORD_MULTIPLY,
        OP_WORD_BY_HALFWORD_MULTIPLY
    } smd_op_t;

endpackage : smd_pkg

// File: core/smd_signed_mult.sv
// Parameterised signed multiplier, full-width product.
// Assumes both inputs are two's complement; purely combinational.
`timescale 1ns/1ns
module smd_signed_mult #(
    parameter int A_W = 16,
    parameter int B_W = 16
) (
    input  wire logic signed [A_W-1:0]     mul_a,
    input  wire logic signed [B_W-1:0]     mul_b,
    output logic signed [A_W+B_W-1:0]      product
);

    // Full product width, so no signed result can overflow
    assign product = mul_a * mul_b;

endmodule : smd_signed_mult

// File: core/smd_multiply_unit.sv
// Signed multiply unit: msw, dual halfword, halfword and word-by-halfword products.
// Assumes an Avalon-MM master on sys_clk; operands are loaded before the start bit is written.
// Function
// RULE1: msw accumulate adds accumulate word to optionally rounded product high word.
// RULE2: msw subtract writes accumulate word minus the product high word.
// RULE3: rounding adds the constant to the full product before taking high word.
// RULE4: msw multiply writes the signed upper 32 bits of the product.
// RULE5: dual sum adds two signed 16 by 16 halfword products.
// RULE6: dual difference writes bottom product minus top product.
// RULE7: exchange swaps the second operand halfwords before pairing.
// RULE8: dual sum and difference flag saturation when the final addition overflows.
// RULE9: msw operations never touch the condition flags.
// RULE10: halfword selectors pick low or high half per operand independently.
// RULE11: halfword multiply writes the full 32-bit signed product.
// RULE12: word-by-halfword writes upper 32 bits of the 48-bit product.
// RULE13: word-by-halfword selects only the second operand half; first is whole.
// RULE14: software never names stack pointer or program counter as operands.
// RULE15: saturation flag is sticky until an explicit software clear.
// RULE16: msw accumulate and subtract wrap modulo 2^32 and set no flag.
`timescale 1ns/1ns
module smd_multiply_unit
    import smd_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic [smd_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [smd_pkg::DATA_W-1:0] avs_writedata,
    input  wire logic [smd_pkg::BE_W-1:0]   avs_byteenable,
    output logic [smd_pkg::DATA_W-1:0]      avs_readdata,
    output logic                           avs_waitrequest,
    output logic                           irq
);
    import smd_pkg::*;

    // Software visible state, then start pulse and read handshake flops
    logic [DATA_W-1:0] first_ff;
    logic [DATA_W-1:0] second_ff;
    logic [DATA_W-1:0] accum_ff;
    logic [CTRL_W-1:0] ctrl_ff;
    logic [DATA_W-1:0] result_ff;
    logic [COND_W-1:0] cond_ff;
    logic [STAT_W-1:0] status_ff;
    logic [STAT_W-1:0] mask_ff;
    logic              go_ff;
    logic              rd_ack_ff;
    logic [DATA_W-1:0] readdata_ff;

    // Next values
    logic [DATA_W-1:0] nxt_first;
    logic [DATA_W-1:0] nxt_second;
    logic [DATA_W-1:0] nxt_accum;
    logic [CTRL_W-1:0] nxt_ctrl;
    logic [DATA_W-1:0] nxt_result;
    logic [COND_W-1:0] nxt_cond;
    logic [STAT_W-1:0] nxt_status;
    logic [STAT_W-1:0] nxt_mask;

    // Bus decode
    wire logic [DATA_W-1:0] be_mask;
    wire logic              wr_first;
    wire logic              wr_second;
    wire logic              wr_accum;
    wire logic              wr_ctrl;
    wire logic              wr_cond;
    wire logic              wr_status;
    wire logic              wr_mask;
    wire logic              start_req;
    wire logic              rd_take;
    wire logic [DATA_W-1:0] rd_mux;

    // Byte lanes expanded to a bit mask
    genvar lane;
    generate
        for (lane = 0; lane < BE_W; lane = lane + 1) begin : g_be
            assign be_mask[lane*BYTE_W +: BYTE_W] = {BYTE_W{avs_byteenable[lane]}};
        end
    endgenerate

    // Write strobes per register; unmapped writes fall through and are ignored
    assign wr_first  = avs_write & (avs_address == REG_FIRST);
    assign wr_second = avs_write & (avs_address == REG_SECOND);
    assign wr_accum  = avs_write & (avs_address == REG_ACCUM);
    assign wr_ctrl   = avs_write & (avs_address == REG_CTRL);
    assign wr_cond   = avs_write & (avs_address == REG_COND);
    assign wr_status = avs_write & (avs_address == REG_STATUS);
    assign wr_mask   = avs_write & (avs_address == REG_MASK);
    // Start bit is self clearing and lives in the top byte lane
    assign start_req = wr_ctrl & avs_byteenable[BE_W-1] & avs_writedata[CTRL_START_BIT];

    // Masked byte merge for plain read-write registers
    function automatic logic [DATA_W-1:0] merge_word(input logic [DATA_W-1:0] old_val,
                                                     input logic [DATA_W-1:0] new_val,
                                                     input logic [DATA_W-1:0] mask);
        merge_word = (old_val & ~mask) | (new_val & mask);
    endfunction : merge_word

    assign nxt_first  = wr_first  ? merge_word(first_ff, avs_writedata, be_mask) : first_ff;
    assign nxt_second = wr_second ? merge_word(second_ff, avs_writedata, be_mask) : second_ff;
    assign nxt_accum  = wr_accum  ? merge_word(accum_ff, avs_writedata, be_mask) : accum_ff;
    assign nxt_ctrl   = (wr_ctrl & avs_byteenable[0]) ? avs_writedata[CTRL_W-1:0] : ctrl_ff;
    assign nxt_mask   = (wr_mask & avs_byteenable[0]) ? avs_writedata[STAT_W-1:0] : mask_ff;
    // RULE9 flags software only
    assign nxt_cond   = (wr_cond & avs_byteenable[BE_W-1]) ?
                        avs_writedata[COND_LSB +: COND_W] : cond_ff;

    // Decoded control fields
    wire smd_op_t           op_sel;
    wire logic              round_en;
    wire logic              exch_en;
    wire logic              sel_first_top;
    wire logic              sel_second_top;

    assign op_sel         = smd_op_t'(ctrl_ff[CTRL_OP_LSB +: CTRL_OP_W]);
    assign round_en       = ctrl_ff[CTRL_ROUND_BIT];
    assign exch_en        = ctrl_ff[CTRL_EXCH_BIT];
    assign sel_first_top  = ctrl_ff[CTRL_SELA_BIT];
    assign sel_second_top = ctrl_ff[CTRL_SELB_BIT];

    // Operand halves
    wire logic [HALF_W-1:0] first_lo;
    wire logic [HALF_W-1:0] first_hi;
    wire logic [HALF_W-1:0] second_lo;
    wire logic [HALF_W-1:0] second_hi;
    wire logic [HALF_W-1:0] pair_lo;
    wire logic [HALF_W-1:0] pair_hi;
    wire logic [HALF_W-1:0] half_a;
    wire logic [HALF_W-1:0] half_b;

    assign first_lo  = first_ff[HALF_W-1:0];
    assign first_hi  = first_ff[DATA_W-1:HALF_W];
    assign second_lo = second_ff[HALF_W-1:0];
    assign second_hi = second_ff[DATA_W-1:HALF_W];
    // RULE7 swap second halves
    assign pair_lo   = exch_en ? second_hi : second_lo;
    assign pair_hi   = exch_en ? second_lo : second_hi;
    // RULE10 independent halfword selectors
    assign half_a    = sel_first_top  ? first_hi  : first_lo;
    // RULE13 second operand half only
    assign half_b    = sel_second_top ? second_hi : second_lo;

    // Products, each at full width
    wire logic signed [WIDE_W-1:0] msw_prod;
    wire logic signed [DATA_W-1:0] dual_bot;
    wire logic signed [DATA_W-1:0] dual_top;
    wire logic signed [DATA_W-1:0] half_prod;
    wire logic signed [WH_W-1:0]   wh_prod;

    smd_signed_mult #(.A_W(DATA_W), .B_W(DATA_W)) u_msw_mult (
        .mul_a   (first_ff),
        .mul_b   (second_ff),
        .product (msw_prod)
    );

    // RULE5 bottom pair product
    smd_signed_mult #(.A_W(HALF_W), .B_W(HALF_W)) u_dual_bot (
        .mul_a   (first_lo),
        .mul_b   (pair_lo),
        .product (dual_bot)
    );

    // RULE5 top pair product
    smd_signed_mult #(.A_W(HALF_W), .B_W(HALF_W)) u_dual_top (
        .mul_a   (first_hi),
        .mul_b   (pair_hi),
        .product (dual_top)
    );

    // RULE11 full halfword product
    smd_signed_mult #(.A_W(HALF_W), .B_W(HALF_W)) u_half_mult (
        .mul_a   (half_a),
        .mul_b   (half_b),
        .product (half_prod)
    );

    // RULE13 whole first word
    smd_signed_mult #(.A_W(DATA_W), .B_W(HALF_W)) u_wh_mult (
        .mul_a   (first_ff),
        .mul_b   (half_b),
        .product (wh_prod)
    );

    // Most significant word path
    // Accumulate and subtract wrap at 32 bits; no overflow is reported
    wire logic [WIDE_W-1:0] msw_rounded;
    wire logic [DATA_W-1:0] msw_hi;
    wire logic [DATA_W-1:0] msw_acc;
    wire logic [DATA_W-1:0] msw_sub;

    // RULE3 round before extraction
    assign msw_rounded = msw_prod + (round_en ? ROUND_CONST : ZERO_WIDE);
    // RULE4 signed upper word
    assign msw_hi      = msw_rounded[WIDE_W-1:DATA_W];
    // RULE1 add accumulate word
    assign msw_acc     = msw_hi + accum_ff;
    // RULE2 accumulate minus high word
    assign msw_sub     = accum_ff - msw_hi;

    // Dual path, one guard bit so overflow of the final addition is visible
    wire logic [DATA_W:0]   dual_sum;
    wire logic [DATA_W:0]   dual_diff;
    wire logic              sum_ovf;
    wire logic              diff_ovf;

    // RULE5 sum of both products
    assign dual_sum  = {dual_bot[DATA_W-1], dual_bot} + {dual_top[DATA_W-1], dual_top};
    // RULE6 bottom minus top
    assign dual_diff = {dual_bot[DATA_W-1], dual_bot} - {dual_top[DATA_W-1], dual_top};
    // RULE8 guard bit disagrees with sign
    assign sum_ovf   = dual_sum[DATA_W] ^ dual_sum[DATA_W-1];
    assign diff_ovf  = dual_diff[DATA_W] ^ dual_diff[DATA_W-1];

    // Result and saturation selection by operation
    logic [DATA_W-1:0] op_result;
    logic              op_ovf;

    always_comb begin
        op_result = RST_WORD;
        op_ovf    = 1'b0;
        case (op_sel)
            // RULE4 plain high word
            OP_MSW_MULTIPLY: begin
                op_result = msw_hi;
            end
            // RULE16 wraps, no flag
            OP_MSW_MULTIPLY_ACCUMULATE: begin
                op_result = msw_acc;
            end
            // RULE16 wraps, no flag
            OP_MSW_MULTIPLY_SUBTRACT: begin
                op_result = msw_sub;
            end
            OP_DUAL_PRODUCT_SUM: begin
                op_result = dual_sum[DATA_W-1:0];
                op_ovf    = sum_ovf;
            end
            OP_DUAL_PRODUCT_DIFFERENCE: begin
                op_result = dual_diff[DATA_W-1:0];
                op_ovf    = diff_ovf;
            end
            // RULE11 whole product kept
            OP_HALFWORD_BY_HALFWORD_MULTIPLY: begin
                op_result = half_prod;
            end
            // RULE12 drop low 16 of 48 bits
            OP_WORD_BY_HALFWORD_MULTIPLY: begin
                op_result = wh_prod[WH_W-1:HALF_W];
            end
            // Unused codes give zero and no flag
            default: begin
                op_result = RST_WORD;
                op_ovf    = 1'b0;
            end
        endcase
    end

    // Result is captured one cycle after the start write
    // Registering keeps the wide multiplier chain off the bus read path
    assign nxt_result = go_ff ? op_result : result_ff;

    // Status events; a hardware set wins over a same-cycle software clear
    wire logic [STAT_W-1:0] stat_set;
    wire logic [STAT_W-1:0] stat_clr;

    // Done is set on every start so software may poll instead of using irq
    assign stat_set[STAT_DONE_BIT] = go_ff;
    // RULE8 flag on dual overflow
    assign stat_set[STAT_SAT_BIT]  = go_ff & op_ovf;
    assign stat_clr = (wr_status & avs_byteenable[0]) ? avs_writedata[STAT_W-1:0] : RST_STAT;
    // RULE15 sticky until cleared
    assign nxt_status = (status_ff & ~stat_clr) | stat_set;

    // Level interrupt while any unmasked status bit stands
    assign irq = |(status_ff & mask_ff);

    // Read mux; unmapped addresses read zero, start bit reads zero
    // The mux may be slow; its output is registered before reaching the bus
    assign rd_mux = (avs_address == REG_FIRST)  ? first_ff :
                    (avs_address == REG_SECOND) ? second_ff :
                    (avs_address == REG_ACCUM)  ? accum_ff :
                    (avs_address == REG_CTRL)   ? {{(DATA_W-CTRL_W){1'b0}}, ctrl_ff} :
                    (avs_address == REG_RESULT) ? result_ff :
                    (avs_address == REG_COND)   ?
                        {cond_ff, {COND_LSB{1'b0}}} :
                    (avs_address == REG_STATUS) ? {{(DATA_W-STAT_W){1'b0}}, status_ff} :
                    (avs_address == REG_MASK)   ? {{(DATA_W-STAT_W){1'b0}}, mask_ff} :
                    RST_WORD;

    // One wait cycle per read so read data comes from a flip-flop
    // Limitation: each read costs two cycles, a write only one
    assign rd_take         = avs_read & ~rd_ack_ff;
    assign avs_waitrequest = rd_take;
    assign avs_readdata    = readdata_ff;

    // Operand and control registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            first_ff  <= RST_WORD;
            second_ff <= RST_WORD;
            accum_ff  <= RST_WORD;
            ctrl_ff   <= RST_CTRL;
            cond_ff   <= RST_COND;
            mask_ff   <= RST_STAT;
        end else begin
            first_ff  <= nxt_first;
            second_ff <= nxt_second;
            accum_ff  <= nxt_accum;
            ctrl_ff   <= nxt_ctrl;
            cond_ff   <= nxt_cond;
            mask_ff   <= nxt_mask;
        end
    end

    // Execution and status
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            go_ff     <= 1'b0;
            result_ff <= RST_WORD;
            status_ff <= RST_STAT;
        end else begin
            go_ff     <= start_req;
            result_ff <= nxt_result;
            status_ff <= nxt_status;
        end
    end

    // Read handshake
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_ack_ff   <= 1'b0;
            readdata_ff <= RST_WORD;
        end else begin
            rd_ack_ff <= rd_take;
            if (rd_take) begin
                readdata_ff <= rd_mux;
            end
        end
    end

endmodule : smd_multiply_unit

// File: verification/smd_opnd_file.sv
// Operand register file model on the issuing side of the multiply unit.
// Assumes the bench picks slots by index; the slot words are fixed test values.
`timescale 1ns/1ns
module smd_opnd_file (
    input  wire logic [2:0]  sel_first,
    input  wire logic [2:0]  sel_second,
    input  wire logic [2:0]  sel_accum,
    output logic [31:0]      word_first,
    output logic [31:0]      word_second,
    output logic [31:0]      word_accum
);
    logic [31:0] slot [8];

    // Test words: most negative, most positive, half extremes and mixed values
    initial slot = '{32'h8000_0000, 32'h7fff_ffff, 32'h8000_8000, 32'h1234_fedc,
                     32'hffff_0001, 32'h0003_8000, 32'h7fff_7fff, 32'hc001_2345};

    // general slots only
    // No index reaches a stack pointer or program counter slot
    assign word_first  = slot[sel_first];
    assign word_second = slot[sel_second];
    assign word_accum  = slot[sel_accum];
endmodule : smd_opnd_file

// File: verification/smd_unit_properties.sv
// Checker of the multiply unit's bus handshake and interrupt output.
// Assumes it is bound into smd_multiply_unit and sees only its ports.
`timescale 1ns/1ns
module smd_unit_checker
    import smd_pkg::*;
(
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic [smd_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [smd_pkg::DATA_W-1:0]  avs_readdata,
    input  wire logic                        avs_waitrequest,
    input  wire logic                        irq
);
    // Read answered at this edge
    wire rd_done = avs_read && !avs_waitrequest;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Writes never stall; a read waits exactly one cycle
    a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
        else $error("write was held off");
    a_idle_no_wait: assert property (!avs_read |-> !avs_waitrequest)
        else $error("waitrequest without a read");
    a_read_first_wait: assert property ($rose(avs_read) |-> avs_waitrequest)
        else $error("read answered without a wait cycle");
    a_read_one_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read waited more than one cycle");
    // Unmapped and reserved bits read as zero
    a_unmapped_zero: assert property (rd_done && avs_address[1:0] != 2'h0
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_start_reads_low: assert property (rd_done && avs_address == REG_CTRL
        |-> !avs_readdata[31]) else $error("start bit read back high");
    a_cond_low_zero: assert property (rd_done && avs_address == REG_COND
        |-> avs_readdata[27:0] == 28'h0) else $error("condition low bits not zero");
    // Only a bus write can lower a raised interrupt
    a_irq_sticky: assert property (irq && !avs_write |=> irq)
        else $error("interrupt dropped without a write");
    a_irq_reset_low: assert property (disable iff (1'b0) rst |=> !irq)
        else $error("interrupt high after reset");
endmodule : smd_unit_checker

bind smd_multiply_unit smd_unit_checker u_chk (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .irq             (irq)
);

// File: verification/tb.sv
// Self-checking bench of the multiply unit over its register bus.
// Assumes smd_pkg register map; operands come from the operand file model.
`timescale 1ns/1ns
module tb;
    import smd_pkg::*;
    logic                sys_clk = 1'b0;
    logic                rst = 1'b1;
    logic [ADDR_W-1:0]   avs_address = '0;
    logic                avs_read = 1'b0;
    logic                avs_write = 1'b0;
    logic [DATA_W-1:0]   avs_writedata = '0;
    logic [BE_W-1:0]     avs_byteenable = '0;
    logic [DATA_W-1:0]   avs_readdata;
    logic                avs_waitrequest;
    logic                irq;
    logic [2:0]          sel_first = '0;
    logic [2:0]          sel_second = '0;
    logic [2:0]          sel_accum = '0;
    logic [31:0]         word_first;
    logic [31:0]         word_second;
    logic [31:0]         word_accum;
    logic                exp_sat = 1'b0;
    logic [3:0]          bus_be = 4'hf;
    int                  n_mismatch = 0;
    int                  samples_checked = 0;

    smd_multiply_unit dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq));
    smd_opnd_file rf (.sel_first(sel_first), .sel_second(sel_second), .sel_accum(sel_accum),
        .word_first(word_first), .word_second(word_second), .word_accum(word_accum));

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One bus cycle; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= bus_be;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            n_mismatch++;
            $display("mismatch waitrequest expected 0 seen %b", avs_waitrequest);
            end_sim();
        end
        // Answer taken at the same edge that saw waitrequest low
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask : rd

    task automatic chk_irq(input logic e);
        @(negedge sys_clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : chk_irq

    // Reference result with saturation flag on top; fl = sel_b, sel_a, exchange, round
    function automatic logic [32:0] exp_op(input logic [3:0] op, input logic [3:0] fl,
                                           input logic [31:0] a, b, c);
        logic signed [63:0] p;
        logic signed [47:0] w;
        logic signed [32:0] lo, hi, d;
        logic [31:0] x;
        logic signed [15:0] ha, hb;
        p = $signed(a) * $signed(b) + (fl[0] ? 64'sh8000_0000 : 64'sh0);
        x = fl[1] ? {b[15:0], b[31:16]} : b;
        lo = $signed(a[15:0]) * $signed(x[15:0]);
        hi = $signed(a[31:16]) * $signed(x[31:16]);
        d = (op == 4'h4) ? lo - hi : lo + hi;
        ha = fl[2] ? a[31:16] : a[15:0];
        hb = fl[3] ? b[31:16] : b[15:0];
        w = $signed(a) * hb;
        case (op)
            4'h0: return {1'b0, p[63:32]};
            4'h1: return {1'b0, p[63:32] + c};
            4'h2: return {1'b0, c - p[63:32]};
            4'h3, 4'h4: return {d[32] ^ d[31], d[31:0]};
            4'h5: begin
                d = ha * hb;
                return {1'b0, d[31:0]};
            end
            4'h6: return {1'b0, w[47:16]};
            default: return 33'h0;
        endcase
    endfunction : exp_op

    // Load operands from the file model, start, then check result and status
    task automatic do_op(input logic [3:0] op, input logic [3:0] fl,
                         input logic [2:0] fi, si, ai);
        logic [31:0] a, b, c, q;
        logic [32:0] e;
        @(posedge sys_clk);
        sel_first <= fi;
        sel_second <= si;
        sel_accum <= ai;
        @(negedge sys_clk);
        a = word_first;
        b = word_second;
        c = word_accum;
        e = exp_op(op, fl, a, b, c);
        exp_sat = exp_sat | e[32];
        wr(REG_FIRST, a);
        wr(REG_SECOND, b);
        wr(REG_ACCUM, c);
        wr(REG_CTRL, {1'b1, 23'h0, fl, op});
        rd(REG_RESULT, q);
        chk("result", e[31:0], q);
        rd(REG_STATUS, q);
        chk("status", {30'h0, exp_sat, 1'b1}, q);
    endtask : do_op

    task automatic t_regs();
        logic [31:0] q;
        for (int i = 0; i < 8; i++) begin
            rd(5'(i * 4), q);
            chk("reset value", 32'h0, q);
        end
        rd(5'h1e, q);
        chk("unmapped", 32'h0, q);
        // Only the enabled byte lane may change
        bus_be = 4'h1;
        wr(REG_FIRST, 32'hffff_ffff);
        bus_be = 4'hf;
        rd(REG_FIRST, q);
        chk("byte lane", 32'h0000_00ff, q);
        wr(REG_COND, 32'hffff_ffff);
        rd(REG_COND, q);
        chk("cond", 32'hf000_0000, q);
        $display("test regs done");
    endtask : t_regs

    task automatic t_msw();
        logic [31:0] q;
        for (int op = 0; op < 3; op++)
            for (int r = 0; r < 2; r++) begin
                do_op(4'(op), 4'(r), 3'h0, 3'h0, 3'h1);
                do_op(4'(op), 4'(r), 3'h3, 3'h4, 3'h5);
            end
        rd(REG_COND, q);
        chk("cond kept", 32'hf000_0000, q);
        $display("test msw done");
    endtask : t_msw

    task automatic t_dual();
        logic [31:0] q;
        for (int op = 3; op < 5; op++)
            for (int x = 0; x < 2; x++) begin
                do_op(4'(op), 4'(x * 2), 3'h3, 3'h5, 3'h0);
                do_op(4'(op), 4'(x * 2), 3'h2, 3'h2, 3'h0);
                do_op(4'(op), 4'(x * 2), 3'h6, 3'h7, 3'h0);
            end
        wr(REG_STATUS, 32'h2);
        exp_sat = 1'b0;
        rd(REG_STATUS, q);
        chk("sat cleared", 32'h1, q);
        $display("test dual done");
    endtask : t_dual

    task automatic t_half();
        for (int s = 0; s < 4; s++) begin
            do_op(4'h5, 4'(s * 4), 3'h3, 3'h4, 3'h0);
            do_op(4'h6, 4'(s * 4 + 1), 3'h0, 3'h5, 3'h0);
            do_op(4'h6, 4'(s * 4), 3'h7, 3'h6, 3'h0);
        end
        // Unused operation code gives zero and no flag
        do_op(4'h7, 4'h1, 3'h1, 3'h1, 3'h0);
        $display("test half done");
    endtask : t_half

    task automatic t_irq();
        wr(REG_STATUS, 32'h3);
        wr(REG_MASK, 32'h1);
        chk_irq(1'b0);
        do_op(4'h0, 4'h0, 3'h3, 3'h4, 3'h0);
        chk_irq(1'b1);
        wr(REG_MASK, 32'h0);
        chk_irq(1'b0);
        wr(REG_MASK, 32'h2);
        chk_irq(1'b0);
        do_op(4'h3, 4'h0, 3'h2, 3'h2, 3'h0);
        chk_irq(1'b1);
        wr(REG_STATUS, 32'h2);
        exp_sat = 1'b0;
        chk_irq(1'b0);
        $display("test irq done");
    endtask : t_irq

    // Main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_msw();
        t_dual();
        t_half();
        t_irq();
        end_sim();
    end
endmodule : tb
